// *** src/sdu_device.sv ***
// conversion update controller: bank timing, sinc3 decimation, data registers, result buffer
`timescale 1ns/1ps
`include "sdu_map.svh"

// Summary of operation
// - control bits 0/1 pick external start
// - external edge latches bank data quickly
// - internal mode uses bank's own divider
// - read bits 2/3 refresh every two cycles
// - internal only when both bits clear
// - divider keeps bits 11:6, rate clk/value
// - software writes dividers 0x180..0xFC0 only
// - modulator runs 64 times update rate
// - bits 7/8 lock banks to pwm
// - equal period and divider: update each period
// - start lags sync by (128-phase)/128 period
// - phase offset valid in single update only
// - lock holds when rate is a multiple
// - result is 16-bit left-justified two's complement
// - sinc3, length 64, one word per period
// - filter latency about 1.5 periods
// - calibration register, one bit per channel
// - calibrating channel tied to reference
// - software stores and subtracts offset code
// - writes raise busy for four periods, except a write to an unused offset or to the divider that bit 9 does not pick
// - update pulse per bank, none in read
module sdu_device #(
  parameter int DEPTH = 2
) (
  input  wire logic          clk_sys_i,
  input  wire logic          arst_n_i,
  sdu_link_if.device         link,
  input  wire logic [4:0]    mod_bit_i,
  output logic      [4:0]    cal_tie_o,
  output logic      [1:0]    mod_strobe_o,
  output logic      [1:0]    bank_update_o,
  output logic      [79:0]   result_o,
  output logic      [1:0]    overrun_o
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] ctrl_q;
  logic [5:0]  div_q [2];
  logic [6:0]  phase_q;
  logic [4:0]  cal_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_q   <= `SDU_CTRL_RST;
      div_q[0] <= `SDU_DIV_RST;
      div_q[1] <= `SDU_DIV_RST;
      phase_q  <= `SDU_PHASE_RST;
      cal_q    <= `SDU_CAL_RST;
    end
    else if (link.wr_en)
    begin
      case (link.wr_addr)
        `SDU_ADDR_CTRL:  ctrl_q <= link.wr_data;
        `SDU_ADDR_DIVA:  div_q[0] <= link.wr_data[`SDU_DIV_MSB:`SDU_DIV_LSB];
        `SDU_ADDR_DIVB:  div_q[1] <= link.wr_data[`SDU_DIV_MSB:`SDU_DIV_LSB];
        `SDU_ADDR_PHASE: phase_q <= link.wr_data[6:0];
        `SDU_ADDR_CAL:   cal_q <= link.wr_data[4:0];
        default:         ctrl_q <= ctrl_q;
      endcase
    end
  end

  function automatic sdu_pkg::sdu_mode_type bank_mode(input logic [15:0] c, input int b);
    if (c[`SDU_BIT_RD_A + b])
      bank_mode = sdu_pkg::SDU_READ;      // read overrides start source
    else if (c[`SDU_BIT_EXT_A + b])
      bank_mode = sdu_pkg::SDU_EXTERNAL;
    else
      bank_mode = sdu_pkg::SDU_INTERNAL;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] meta_q;
  logic [6:0] sync_q;
  logic       conv_prev_q;
  logic       conv_rise;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_q      <= 7'h00;
      sync_q      <= 7'h00;
      conv_prev_q <= 1'b0;
    end
    else
    begin
      meta_q      <= {link.pwm_sync, link.convert_start_pin, mod_bit_i};
      sync_q      <= meta_q;
      conv_prev_q <= sync_q[5];
    end
  end
  assign conv_rise = sync_q[5] & ~conv_prev_q;

  // ----------------------------------------------------------------
  // per-bank timing
  // ----------------------------------------------------------------
  logic [1:0]  conv_evt;
  logic [1:0]  latch_evt;
  logic [1:0]  period_tick;
  logic [1:0]  mod_en;
  logic [1:0]  pend_q;
  logic [1:0]  pwm_rise;
  logic        pwm_prev_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pwm_prev_q <= 1'b0;
    else
      pwm_prev_q <= sync_q[6];
  end

  for (genvar b = 0; b < 2; b++)
  begin : g_bank
    logic [11:0] cnt_q;
    logic [5:0]  mcnt_q;
    logic        half_q;
    logic [11:0] period;
    logic [11:0] target;
    logic [12:0] lag;
    logic        restart;
    sdu_pkg::sdu_mode_type mode;

    assign mode    = bank_mode(ctrl_q, b);
    assign period  = {(div_q[b] == 6'h00) ? 6'h01 : div_q[b], 6'h00};
    assign restart = ctrl_q[`SDU_BIT_SYNC_A + b] & pwm_rise[b];
    assign pwm_rise[b] = sync_q[6] & ~pwm_prev_q;
    // lag in cycles = (128 - phase) * period / 128, period already a multiple of 64
    assign lag     = 13'((8'd128 - {1'b0, phase_q}) * div_q[b]) >> 1;
    assign target  = (lag >= {1'b0, period}) ? 12'h000 : lag[11:0];
    // compare with >= so a shorter divider written mid-count cannot run the counter through 4096
    assign period_tick[b] = (cnt_q >= period - 12'h001);
    assign mod_en[b]      = (mcnt_q == 6'h00);

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
      if (!arst_n_i)
      begin
        cnt_q  <= 12'h000;
        mcnt_q <= 6'h00;
        half_q <= 1'b0;
      end
      else
      begin
        // sync restart keeps lock also when the pwm period is a multiple
        cnt_q  <= (restart || period_tick[b]) ? 12'h000 : cnt_q + 12'h001;
        mcnt_q <= (restart || mcnt_q >= div_q[b] - 6'h01) ? 6'h00 : mcnt_q + 6'h01;
        half_q <= ~half_q;
      end
    end

    always_comb
    begin
      case (mode)
        sdu_pkg::SDU_EXTERNAL: conv_evt[b] = conv_rise;
        sdu_pkg::SDU_INTERNAL: conv_evt[b] = ctrl_q[`SDU_BIT_SYNC_A + b] ?
                                             (cnt_q == target) : period_tick[b];
        default:               conv_evt[b] = 1'b0;
      endcase
    end
    // read mode refreshes every second cycle and raises no update pulse
    assign latch_evt[b] = (mode == sdu_pkg::SDU_READ) ? half_q : conv_evt[b];
    assign bank_update_o[b] = conv_evt[b] & ~pend_q[b];
    assign mod_strobe_o[b]  = mod_en[b];
  end

  // ----------------------------------------------------------------
  // sinc3 decimation and data registers
  // ----------------------------------------------------------------
  assign cal_tie_o = cal_q;
  logic tone_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tone_q <= 1'b0;
    else
      tone_q <= ~tone_q;
  end

  for (genvar c = 0; c < 5; c++)
  begin : g_chan
    localparam int B = (c < 2) ? 0 : 1;
    logic signed [20:0] i1_q, i2_q, i3_q, d1_q, d2_q, d3_q, flt_q;
    logic signed [20:0] c1, c2, c3, x;
    logic        [15:0] data_q;
    logic               bit_in;

    // reference-tied input gives a balanced stream, i.e. the channel offset, only with an odd divider
    assign bit_in = cal_q[c] ? tone_q : sync_q[c];
    assign x  = bit_in ? 21'sd1 : -21'sd1;
    assign c1 = i3_q - d1_q;
    assign c2 = c1 - d2_q;
    assign c3 = c2 - d3_q;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
      if (!arst_n_i)
      begin
        {i1_q, i2_q, i3_q} <= '0;
        {d1_q, d2_q, d3_q, flt_q} <= '0;
        data_q <= 16'h0000;
      end
      else
      begin
        if (mod_en[B])
        begin
          i1_q <= i1_q + x;
          i2_q <= i2_q + i1_q;
          i3_q <= i3_q + i2_q;
        end
        // combs at the word rate: three stages give the ~1.5 period delay
        if (period_tick[B])
        begin
          d1_q  <= i3_q;
          d2_q  <= c1;
          d3_q  <= c2;
          flt_q <= c3;
        end
        if (latch_evt[B] && !pend_q[B])
          // +/-2^18 full scale; clamp the single positive overflow code
          data_q <= (flt_q >= 21'sd262144) ? 16'h7fff : flt_q[18:3];
      end
    end
    assign result_o[c*16 +: 16] = data_q;
  end

  // ----------------------------------------------------------------
  // busy flag
  // ----------------------------------------------------------------
  logic [2:0] busy_q;
  logic       bsel;
  logic       busy_wr;

  assign bsel    = ctrl_q[`SDU_BIT_BUSYSEL];
  assign busy_wr = link.wr_en && (link.wr_addr == `SDU_ADDR_CTRL || link.wr_addr == `SDU_ADDR_CAL ||
                   link.wr_addr == `SDU_ADDR_PHASE ||
                   link.wr_addr == (bsel ? `SDU_ADDR_DIVB : `SDU_ADDR_DIVA));

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      busy_q <= 3'h0;
    else if (busy_wr)
      busy_q <= `SDU_BUSY_PERIODS; // write restarts the count
    else if (busy_q != 3'h0 && period_tick[bsel])
      busy_q <= busy_q - 3'h1;
  end
  assign link.busy = (busy_q != 3'h0);

  // ----------------------------------------------------------------
  // result buffer
  // ----------------------------------------------------------------
  // a bank holds its data registers while its word waits, so no word is overwritten
  logic [1:0]            pend_seen_q;
  logic                  push;
  logic                  push_bank;
  logic                  full;
  logic                  empty;
  logic [1:0]            wptr_q, rptr_q;
  logic [$clog2(DEPTH):0] cnt_q;
  sdu_pkg::sdu_word_type mem_q [DEPTH];

  assign push_bank = ~pend_q[0];
  assign full      = (cnt_q == DEPTH);
  assign empty     = (cnt_q == '0);
  assign push      = (pend_q != 2'b00) && !full;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pend_q      <= 2'b00;
      pend_seen_q <= 2'b00;
    end
    else
    begin
      for (int b = 0; b < 2; b++)
      begin
        // the clearing push wins over a new conversion of the same bank, which is dropped
        if (conv_evt[b] && !pend_q[b])
          pend_q[b] <= 1'b1;
        else if (push && push_bank == b[0])
          pend_q[b] <= 1'b0;
        pend_seen_q[b] <= conv_evt[b] & pend_q[b];
      end
    end
  end
  assign overrun_o = pend_seen_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wptr_q <= 2'h0;
      rptr_q <= 2'h0;
      cnt_q  <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wptr_q[$clog2(DEPTH)-1:0]] <= push_bank ?
          sdu_pkg::sdu_word_type'{1'b1, result_o[79:32]} :
          sdu_pkg::sdu_word_type'{1'b0, {16'h0000, result_o[31:0]}};
        wptr_q <= wptr_q + 2'h1;
      end
      if (link.res_ready && !empty)
        rptr_q <= rptr_q + 2'h1;
      cnt_q <= cnt_q + (push ? 1'b1 : 1'b0) - ((link.res_ready && !empty) ? 1'b1 : 1'b0);
    end
  end
  assign link.res_valid = !empty;
  assign link.res_word  = mem_q[rptr_q[$clog2(DEPTH)-1:0]];
endmodule

// *** common/sdu_map.svh ***
// register offsets, field positions, reset values and counts of the update controller
`ifndef SDU_MAP_SVH
`define SDU_MAP_SVH
`define SDU_ADDR_CTRL    3'h0
`define SDU_ADDR_DIVA    3'h1
`define SDU_ADDR_DIVB    3'h2
`define SDU_ADDR_PHASE   3'h3
`define SDU_ADDR_CAL     3'h4
`define SDU_ADDR_PWMPER  3'h5
`define SDU_BIT_EXT_A    0
`define SDU_BIT_RD_A     2
`define SDU_BIT_SYNC_A   7
`define SDU_BIT_BUSYSEL  9
`define SDU_DIV_LSB      6
`define SDU_DIV_MSB      11
`define SDU_CTRL_RST     16'h0000
`define SDU_DIV_RST      6'h06
`define SDU_PHASE_RST    7'h00
`define SDU_CAL_RST      5'h00
`define SDU_PWMPER_RST   16'h0180
`define SDU_BUSY_PERIODS 3'h4
`define SDU_SLICES       128
`define SDU_OSR          64
`endif

// *** common/sdu_pkg.sv ***
// types shared by both ends of the update controller
package sdu_pkg;
  typedef enum logic [1:0]
  {
    SDU_INTERNAL = 2'b00,
    SDU_EXTERNAL = 2'b01,
    SDU_READ     = 2'b10
  } sdu_mode_type;
  typedef struct packed
  {
    logic        bank;
    logic [47:0] data;
  } sdu_word_type;
endpackage

// *** common/sdu_link_if.sv ***
// link between the processor/pwm side and the conversion update controller
`timescale 1ns/1ps
interface sdu_link_if;
  logic                 wr_en;
  logic [2:0]           wr_addr;
  logic [15:0]          wr_data;
  logic                 pwm_sync;
  logic                 convert_start_pin;
  logic                 busy;
  logic                 res_valid;
  logic                 res_ready;
  sdu_pkg::sdu_word_type res_word;
  modport device (input wr_en, wr_addr, wr_data, pwm_sync, convert_start_pin, res_ready,
                  output busy, res_valid, res_word);
  modport host   (output wr_en, wr_addr, wr_data, pwm_sync, convert_start_pin, res_ready,
                  input busy, res_valid, res_word);
endinterface

// *** src/sdu_host.sv ***
// processor/pwm end: register writes, pwm period sync, convert-start pin, result drain
`timescale 1ns/1ps
`include "sdu_map.svh"

module sdu_host (
  input  wire logic          clk_sys_i,
  input  wire logic          arst_n_i,
  sdu_link_if.host           link,
  input  wire logic          wr_valid_i,
  input  wire logic [2:0]    wr_addr_i,
  input  wire logic [15:0]   wr_data_i,
  output logic               wr_ready_o,
  input  wire logic          convert_start_i,
  output logic               busy_o,
  output logic               pwm_sync_o,
  output logic               res_valid_o,
  input  wire logic          res_ready_i,
  output sdu_pkg::sdu_word_type res_word_o
);
  // ----------------------------------------------------------------
  // register writes and pwm period
  // ----------------------------------------------------------------
  logic        wr_q;
  logic [2:0]  addr_q;
  logic [15:0] data_q;
  logic [15:0] pwm_per_q;
  logic [15:0] pwm_cnt_q;
  logic        sync_q;
  logic        conv_q;

  assign wr_ready_o = 1'b1;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_q      <= 1'b0;
      addr_q    <= 3'h0;
      data_q    <= 16'h0000;
      pwm_per_q <= `SDU_PWMPER_RST;
      pwm_cnt_q <= 16'h0000;
      sync_q    <= 1'b0;
      conv_q    <= 1'b0;
    end
    else
    begin
      // the pwm period register is local; all other offsets go across
      wr_q   <= wr_valid_i && (wr_addr_i != `SDU_ADDR_PWMPER);
      addr_q <= wr_addr_i;
      data_q <= wr_data_i;
      if (wr_valid_i && wr_addr_i == `SDU_ADDR_PWMPER)
        pwm_per_q <= wr_data_i;
      // single update mode only: one sync per period
      pwm_cnt_q <= (pwm_cnt_q >= pwm_per_q - 16'h0001) ? 16'h0000 : pwm_cnt_q + 16'h0001;
      sync_q    <= (pwm_cnt_q == 16'h0000);
      conv_q    <= convert_start_i;
    end
  end
  assign link.wr_en             = wr_q;
  assign link.wr_addr           = addr_q;
  assign link.wr_data           = data_q;
  assign link.pwm_sync          = sync_q;
  assign link.convert_start_pin = conv_q;
  assign pwm_sync_o             = sync_q;
  assign busy_o                 = link.busy;

  // ----------------------------------------------------------------
  // result drain
  // ----------------------------------------------------------------
  // software subtracts stored offsets from these words
  logic                  out_v_q;
  sdu_pkg::sdu_word_type out_q;

  assign link.res_ready = !out_v_q || res_ready_i;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      out_v_q <= 1'b0;
      out_q   <= '0;
    end
    else if (link.res_ready)
    begin
      out_v_q <= link.res_valid;
      if (link.res_valid)
        out_q <= link.res_word;
    end
  end
  assign res_valid_o = out_v_q;
  assign res_word_o  = out_q;
endmodule

// *** sim/sdu_link_properties.sv ***
// concurrent checks on the link between the host end and the update controller
`timescale 1ns/1ps
`include "sdu_map.svh"
module sdu_link_properties (
  input wire logic                  clk_sys_i,
  input wire logic                  arst_n_i,
  input wire logic                  wr_en,
  input wire logic [2:0]            wr_addr,
  input wire logic [15:0]           wr_data,
  input wire logic                  pwm_sync,
  input wire logic                  convert_start_pin,
  input wire logic                  busy,
  input wire logic                  res_valid,
  input wire logic                  res_ready,
  input wire sdu_pkg::sdu_word_type res_word
);
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  // ----------------------------------------
  // register shadows and cycle counters
  // ----------------------------------------
  logic [15:0] ctrl_q;
  logic [5:0]  diva_q;
  logic [6:0]  phase_q;
  logic [31:0] gap_q;
  logic [31:0] since_q;
  logic [31:0] run_q;
  logic [4:0]  rd_q;
  logic        gap_ok_q;
  logic        sync_ok_q;
  logic [31:0] per;
  logic [31:0] off;
  logic        take_a;
  logic        busy_wr;
  assign take_a  = res_valid && res_ready && !res_word.bank;
  assign per     = 32'(diva_q) * 32'h0000_0040;
  assign off     = ((32'h0000_0080 - 32'(phase_q)) * 32'(diva_q) / 32'h0000_0002) % per;
  assign busy_wr = wr_en && (wr_addr inside {`SDU_ADDR_CTRL, `SDU_ADDR_PHASE, `SDU_ADDR_CAL}
                   || wr_addr == (ctrl_q[`SDU_BIT_BUSYSEL] ? `SDU_ADDR_DIVB : `SDU_ADDR_DIVA));
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_q  <= `SDU_CTRL_RST;
      diva_q  <= `SDU_DIV_RST;
      phase_q <= `SDU_PHASE_RST;
    end
    else if (wr_en)
    begin
      if (wr_addr == `SDU_ADDR_CTRL)
        ctrl_q <= wr_data;
      if (wr_addr == `SDU_ADDR_DIVA)
        diva_q <= wr_data[`SDU_DIV_MSB:`SDU_DIV_LSB];
      if (wr_addr == `SDU_ADDR_PHASE)
        phase_q <= wr_data[6:0];
    end
  end
  // any write drops the timing history: a new setting may move the next update
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      gap_q     <= '0;
      since_q   <= '0;
      run_q     <= '0;
      rd_q      <= '0;
      gap_ok_q  <= 1'b0;
      sync_ok_q <= 1'b0;
    end
    else
    begin
      gap_q     <= take_a ? '0 : gap_q + 32'h0000_0001;
      since_q   <= pwm_sync ? '0 : since_q + 32'h0000_0001;
      run_q     <= (!busy || wr_en) ? '0 : run_q + 32'h0000_0001;
      rd_q      <= (ctrl_q[3:2] != 2'b11 || wr_en) ? '0 : rd_q + 5'(rd_q != 5'h1f);
      gap_ok_q  <= !wr_en && (take_a || (gap_ok_q && res_ready));
      sync_ok_q <= !wr_en && (pwm_sync || sync_ok_q);
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_busy_on_write: assert property (busy_wr |=> busy)
    else $error("busy did not follow a write");
  a_busy_cause: assert property (!busy && !busy_wr |=> !busy)
    else $error("busy rose without a write");
  a_busy_length: assert property ($fell(busy) && !ctrl_q[9] && !ctrl_q[7] |->
    run_q + 32'h0000_0004 > per * 32'h0000_0003 && run_q < per * 32'h0000_0004 + 32'h0000_0010)
    else $error("busy width is not four periods");
  a_sync_one_cycle: assert property (pwm_sync |=> !pwm_sync)
    else $error("period sync is not a single pulse");
  a_word_holds: assert property (res_valid && !res_ready |=> res_valid && $stable(res_word))
    else $error("result word changed while stalled");
  a_ext_start: assert property ($rose(convert_start_pin) && ctrl_q[0] && !ctrl_q[2] && !res_valid
    |-> ##[2:5] res_valid)
    else $error("external start gave no word in time");
  a_read_quiet: assert property (rd_q == 5'h1f |-> !res_valid)
    else $error("word pushed in read mode");
  a_int_period: assert property (take_a && gap_ok_q && ctrl_q[2:0] == 3'b000 && !ctrl_q[7]
    |-> gap_q == per - 32'h0000_0001)
    else $error("internal update spacing wrong");
  a_sync_phase: assert property (take_a && sync_ok_q && ctrl_q[7] && !ctrl_q[0] && !ctrl_q[2]
    |-> ((since_q + per - off) % per) inside {[1:10]})
    else $error("synced update off its phase slot");
  c_sync_take: cover property (take_a && ctrl_q[7]);
  c_busy_end: cover property ($fell(busy));
  c_stall: cover property (res_valid && !res_ready);
endmodule

// *** sim/sdu_test.sv ***
// self-checking bench: host end and update controller joined by the link
`timescale 1ns/1ps
`include "sdu_map.svh"
module sdu_test;
  logic                  clk_sys_i;
  logic                  arst_n_i;
  logic                  wr_valid_i;
  logic [2:0]            wr_addr_i;
  logic [15:0]           wr_data_i;
  logic                  convert_start_i;
  logic                  res_ready_i;
  logic [4:0]            mod_bit_i;
  logic [4:0]            cal_tie;
  logic [1:0]            strobe;
  logic [1:0]            bank_update;
  logic [79:0]           result;
  logic [1:0]            overrun;
  logic                  busy;
  logic                  pwm_sync;
  logic                  res_valid;
  sdu_pkg::sdu_word_type res_word;
  int                    num_errors;
  int                    check_count;
  int                    n_upd;
  int                    n_ovr;
  int                    n_strb;
  int                    t;
  logic                  b;
  sdu_link_if link ();
  sdu_device sdu_device_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .link(link), .mod_bit_i(mod_bit_i),
    .cal_tie_o(cal_tie), .mod_strobe_o(strobe), .bank_update_o(bank_update), .result_o(result),
    .overrun_o(overrun));
  sdu_host sdu_host_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .link(link), .wr_valid_i(wr_valid_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .wr_ready_o(), .convert_start_i(convert_start_i),
    .busy_o(busy), .pwm_sync_o(pwm_sync), .res_valid_o(res_valid), .res_ready_i(res_ready_i),
    .res_word_o(res_word));
  sdu_link_properties sdu_link_properties_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .wr_en(link.wr_en),
    .wr_addr(link.wr_addr), .wr_data(link.wr_data), .pwm_sync(link.pwm_sync),
    .convert_start_pin(link.convert_start_pin), .busy(link.busy), .res_valid(link.res_valid),
    .res_ready(link.res_ready), .res_word(link.res_word));
  // ----------------------------------------
  // clock, monitors, tasks
  // ----------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    if (bank_update !== 2'b00) n_upd++;
    if (overrun !== 2'b00) n_ovr++;
    if (strobe[0] === 1'b1) n_strb++;
  end
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // request stays up between back-to-back writes; settle drops it
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    wr_valid_i = 1'b1;
    wr_addr_i = a;
    wr_data_i = d;
    step(1);
  endtask
  task automatic settle(input int n);
    wr_valid_i = 1'b0;
    step(n);
  endtask
  task automatic to_update(input int k, output int n);
    n = 0;
    while (bank_update[k] !== 1'b1 && n < 5000)
    begin
      step(1);
      n++;
    end
  endtask
  task automatic period(input int k, output int n);
    to_update(k, n);
    step(1);
    n_strb = 0;
    to_update(k, n);
  endtask
  task automatic sync_gap(output int n);
    n = 0;
    while (pwm_sync !== 1'b1 && n < 5000)
    begin
      step(1);
      n++;
    end
    to_update(0, n);
  endtask
  task automatic get_bank(output logic bk);
    int n;
    n = 0;
    while (res_valid !== 1'b1 && n < 100)
    begin
      step(1);
      n++;
    end
    bk = res_word.bank;
    step(1);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #200000;
    num_errors++;
    end_of_test();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    arst_n_i = 1'b0;
    wr_valid_i = 1'b0;
    wr_addr_i = 3'h0;
    wr_data_i = 16'h0000;
    convert_start_i = 1'b0;
    res_ready_i = 1'b1;
    mod_bit_i = 5'h1f;
    step(3);
    arst_n_i = 1'b1;
    check({busy, res_valid, cal_tie}, 7'h00);
    wr(3'h6, 16'hffff);
    wr(3'h7, 16'hffff);
    wr(`SDU_ADDR_DIVB, 16'h0180);
    settle(3);
    check(busy, 1'b0);
    wr(`SDU_ADDR_CTRL, 16'h0202);
    wr(`SDU_ADDR_DIVB, 16'h0180);
    wr(`SDU_ADDR_CTRL, 16'h0002);
    settle(2);
    check(busy, 1'b1);
    period(0, t);
    check(t, 16'h017f);
    check(n_strb inside {[63:65]}, 1'b1);
    wr(`SDU_ADDR_DIVA, 16'h01c0);
    settle(1);
    period(0, t);
    check(t, 16'h01bf);
    // let the three comb stages flush the periods around the divider change
    repeat (2) period(0, t);
    check(result[15:0], 16'h7fff);
    wr(`SDU_ADDR_CTRL, 16'h0003);
    settle(20);
    convert_start_i = 1'b1;
    to_update(1, t);
    check(t inside {[2:6]}, 1'b1);
    check(bank_update, 2'b11);
    get_bank(b);
    check(b, 1'b0);
    get_bank(b);
    check(b, 1'b1);
    // stalled drain: starts must be dropped, never overwrite a waiting word
    convert_start_i = 1'b0;
    res_ready_i = 1'b0;
    n_ovr = 0;
    repeat (4)
    begin
      step(4);
      convert_start_i = 1'b1;
      step(4);
      convert_start_i = 1'b0;
    end
    check(n_ovr != 0, 1'b1);
    res_ready_i = 1'b1;
    step(30);
    check(res_valid, 1'b0);
    wr(`SDU_ADDR_CTRL, 16'h000c);
    settle(10);
    n_upd = 0;
    step(200);
    check(n_upd, 0);
    check(res_valid, 1'b0);
    wr(`SDU_ADDR_PWMPER, 16'h0180);
    wr(`SDU_ADDR_DIVA, 16'h0180);
    wr(`SDU_ADDR_PHASE, 16'h0060);
    wr(`SDU_ADDR_CTRL, 16'h0082);
    settle(1);
    sync_gap(t);
    sync_gap(t);
    check(t inside {[95:103]}, 1'b1);
    wr(`SDU_ADDR_PHASE, 16'h0000);
    settle(1);
    sync_gap(t);
    sync_gap(t);
    check(t <= 6, 1'b1);
    // pwm period three times the divider: three updates per pwm period
    wr(`SDU_ADDR_PWMPER, 16'h0480);
    wr(`SDU_ADDR_PHASE, 16'h0040);
    settle(1);
    sync_gap(t);
    sync_gap(t);
    check(t inside {[191:199]}, 1'b1);
    period(0, t);
    check(t, 16'h017f);
    wr(`SDU_ADDR_CAL, 16'h0015);
    settle(2);
    check(cal_tie, 5'h15);
    wr(`SDU_ADDR_CAL, 16'h0000);
    settle(2);
    check(cal_tie, 5'h00);
    end_of_test();
  end
endmodule
